// file: chained_segment_move_sequencer_test.sv
`timescale 1ns/100ps
module chained_segment_move_sequencer_test;
  logic        core_clk;
  logic        resetn;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        estop_pin;
  logic        lim_cw_pin;
  logic        lim_ccw_pin;
  logic        configured;
  logic        cmd_mode;
  logic        config_load;
  logic        step;
  logic        dir_cw;
  logic        nv_locked;
  int          failures;
  int          compares;
  int          steps;
  int          ccw_steps;
  int          cycles;

  cms_link_if link ();
  cms_host cms_host_i (.core_clk(core_clk), .resetn(resetn), .link(link), .addr(addr), .wdata(wdata),
                       .wr(wr), .rd(rd), .rdata(rdata));
  cms_device cms_device_i (.core_clk(core_clk), .resetn(resetn), .link(link), .estop_pin(estop_pin),
                           .lim_cw_pin(lim_cw_pin), .lim_ccw_pin(lim_ccw_pin), .configured(configured),
                           .cmd_mode(cmd_mode), .config_load(config_load), .step(step), .dir_cw(dir_cw),
                           .nv_locked(nv_locked));
  cms_link_monitor cms_link_monitor_i (.core_clk(core_clk), .resetn(resetn), .load_req(link.load_req),
    .seg_valid(link.seg_valid), .start(link.start), .hold(link.hold), .halt_now(link.halt_now),
    .clear_faults(link.clear_faults), .load_active(link.load_active), .seg_request(link.seg_request),
    .cmd_fault(link.cmd_fault), .busy(link.busy), .profile_valid(link.profile_valid));

  // ==========================================================
  // Clock, step counting and hang guard.
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (step === 1'b1)
    begin
      steps++;
      if (dir_cw === 1'b0) ccw_steps++;
    end
    if (cycles == 30000)
    begin
      failures++;
      end_sim();
    end
  end

  // ==========================================================
  // Shared tasks.
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_stat(output logic [31:0] v);
    @(posedge core_clk);
    addr <= cms_pkg::ADR_STAT;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_stat
  task ctl(input int b);
    wr_reg(cms_pkg::ADR_CTRL, 32'h0000_0001 << b);
  endtask : ctl
  task push(input logic [23:0] t);
    logic [31:0] v;
    wr_reg(cms_pkg::ADR_TGT, {8'h00, t});
    wr_reg(cms_pkg::ADR_PAR, 32'h0002_0004);
    ctl(cms_pkg::CB_PUSH);
    repeat (3) @(posedge core_clk);
    repeat (40)
    begin
      rd_stat(v);
      if (v[cms_pkg::SB_PUSHING] === 1'b0 && link.seg_request === 1'b1) break;
    end
    check("push done", 1, link.seg_request);
  endtask : push
  // A start resets the step tally, so every count below is for one move only.
  task run(input logic pausing, input logic cw, input logic ccw, input logic [15:0] pause);
    wr_reg(cms_pkg::ADR_RUN, {13'h0000, ccw, cw, pausing, pause});
    steps = 0;
    ccw_steps = 0;
    ctl(cms_pkg::CB_START);
    repeat (3) @(posedge core_clk);
  endtask : run
  task wait_idle;
    repeat (3000)
    begin
      if (link.busy !== 1'b1) break;
      @(posedge core_clk);
    end
    repeat (2) @(posedge core_clk);
    check("move ended", 0, link.busy);
  endtask : wait_idle

  // ==========================================================
  // Scenarios.
  task t_load;
    logic [31:0] v;
    run(1'b0, 1'b1, 1'b0, 16'h0000);
    check("fault no profile", 1, link.cmd_fault);
    ctl(cms_pkg::CB_CLEAR);
    ctl(cms_pkg::CB_LOAD_BEGIN);
    repeat (3) @(posedge core_clk);
    check("load active", 1, link.load_active);
    check("seg request", 1, link.seg_request);
    ctl(cms_pkg::CB_START);
    rd_stat(v);
    check("start while loading", 1, v[cms_pkg::SB_HOST_ERR]);
    push(24'h00_0005);
    push(24'h00_0000);
    check("bad segment fault", 1, link.cmd_fault);
    ctl(cms_pkg::CB_CLEAR);
    push(24'hff_fffd);
    push(24'h00_0004);
    check("active held", 1, link.load_active);
    ctl(cms_pkg::CB_LOAD_END);
    repeat (3) @(posedge core_clk);
    check("active cleared", 0, {link.load_active, link.seg_request});
    check("profile valid", 1, link.profile_valid);
    check("no fault", 0, link.cmd_fault);
    $display("test load done");
  endtask : t_load
  task t_moves;
    run(1'b0, 1'b1, 1'b0, 16'h0000);
    wait_idle();
    check("cw steps", 12, steps);
    check("cw ccw steps", 0, ccw_steps);
    run(1'b0, 1'b0, 1'b1, 16'h0000);
    wait_idle();
    check("ccw steps", 12, ccw_steps);
    cycles = 0;
    run(1'b1, 1'b0, 1'b0, 16'h0001);
    wait_idle();
    check("pausing ccw steps", 3, ccw_steps);
    check("pausing steps", 12, steps);
    check("pause length", 1, cycles >= 2 * cms_pkg::PAUSE_UNIT_CYC && cycles < 3 * cms_pkg::PAUSE_UNIT_CYC);
    $display("test moves done");
  endtask : t_moves
  task t_stops;
    run(1'b0, 1'b1, 1'b0, 16'h0000);
    ctl(cms_pkg::CB_HOLD);
    wait_idle();
    check("hold short", 1, steps < 12);
    check("hold keeps profile", 1, link.profile_valid);
    run(1'b0, 1'b1, 1'b0, 16'h0000);
    ctl(cms_pkg::CB_HALT);
    repeat (2) @(posedge core_clk);
    check("halt", 0, link.busy);
    run(1'b0, 1'b1, 1'b0, 16'h0000);
    estop_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    check("estop", 0, link.busy);
    estop_pin <= 1'b0;
    run(1'b0, 1'b1, 1'b0, 16'h0000);
    lim_cw_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    check("limit stop", 0, link.busy);
    lim_cw_pin <= 1'b0;
    run(1'b0, 1'b1, 1'b0, 16'h0000);
    check("limit blocks", 1, {link.cmd_fault, link.busy} == 2'b10);
    ctl(cms_pkg::CB_CLEAR);
    run(1'b0, 1'b1, 1'b0, 16'h0000);
    check("cleared runs", 1, link.busy);
    wait_idle();
    run(1'b1, 1'b0, 1'b0, 16'h0001);
    ctl(cms_pkg::CB_HOLD);
    wait_idle();
    check("pause hold short", 1, steps < 5);
    config_load <= 1'b1;
    @(posedge core_clk);
    config_load <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("config drops profile", 0, link.profile_valid);
    $display("test stops done");
  endtask : t_stops
  // Reset stands for a power cycle here; the saved profile must come back without a reload.
  task t_flash;
    wr_reg(cms_pkg::ADR_CTRL, (32'h0000_0001 << cms_pkg::CB_LOAD_BEGIN) |
                              (32'h0000_0001 << cms_pkg::CB_SAVE));
    push(24'h00_0002);
    push(24'hff_fffe);
    ctl(cms_pkg::CB_LOAD_END);
    repeat (3) @(posedge core_clk);
    check("locked after save", 1, nv_locked);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("restored", 1, link.profile_valid);
    run(1'b0, 1'b1, 1'b0, 16'h0000);
    wait_idle();
    check("restored steps", 4, steps);
    $display("test flash done");
  endtask : t_flash

  // ==========================================================
  // Main sequence.
  initial
  begin
    resetn = 1'b0;
    addr = 5'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    estop_pin = 1'b0;
    lim_cw_pin = 1'b0;
    lim_ccw_pin = 1'b0;
    configured = 1'b1;
    cmd_mode = 1'b1;
    config_load = 1'b0;
    failures = 0;
    compares = 0;
    cycles = 0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    t_load();
    t_moves();
    t_stops();
    t_flash();
    end_sim();
  end
endmodule : chained_segment_move_sequencer_test

// file: cms_device.sv
`timescale 1ns/100ps
module cms_device (
  input  wire logic core_clk,
  input  wire logic resetn,
  cms_link_if.dev   link,
  input  wire logic estop_pin,
  input  wire logic lim_cw_pin,
  input  wire logic lim_ccw_pin,
  input  wire logic configured,
  input  wire logic cmd_mode,
  input  wire logic config_load,
  output logic      step,
  output logic      dir_cw,
  output logic      nv_locked
);
  typedef enum logic [2:0] {S_IDLE, S_LREQ, S_LCHK, S_LWAIT, S_RUN, S_PAUSE} cms_dev_state_type;

  typedef struct packed {
    cms_dev_state_type st;
    logic        ld;
    logic        sreq;
    logic        flt;
    logic        busy;
    logic        valid;
    logic        fl_use;
    logic        cont;
    logic        rdir;
    logic        dir;
    logic        step;
    logic        hold;
    logic        sv;
    logic        lock;
    logic        rest_done;
    logic        blk_cw;
    logic        blk_ccw;
    logic [3:0]  idx;
    logic [4:0]  cnt;
    logic [23:0] left;
    logic [15:0] tick;
    logic [15:0] pcnt;
    logic [7:0]  pre;
    logic        p_ld;
    logic        p_sv;
    logic        p_st;
    logic        p_hd;
    logic        p_hn;
    logic        p_es;
    logic [1:0]  es_s;
    logic [1:0]  lw_s;
    logic [1:0]  lc_s;
  } cms_dev_reg_type;

  localparam logic [4:0] SEG_MAX_W  = 5'(cms_pkg::SEG_MAX);
  localparam logic [4:0] SEG_MIN_W  = 5'(cms_pkg::SEG_MIN);
  localparam logic [7:0] PRE_RELOAD = 8'(cms_pkg::PAUSE_UNIT_CYC - 1);

  cms_dev_reg_type      q;
  cms_dev_reg_type      d;
  cms_pkg::cms_seg_type ram   [cms_pkg::SEG_MAX];
  cms_pkg::cms_seg_type flash [cms_pkg::SEG_MAX];
  logic [4:0]           flash_cnt;
  logic [31:0]          flash_sig;
  logic                 es_rise;
  logic                 hn_rise;
  logic                 ld_rise;
  logic                 sv_rise;
  logic                 st_rise;
  logic                 hd_rise;
  logic                 go;
  logic [3:0]           gi;
  logic                 bad;
  logic                 wr_seg;
  logic                 ld_exit;
  logic                 lim_dir;
  cms_pkg::cms_seg_type s;

  function automatic logic [23:0] mag_of(input logic signed [23:0] t);
    mag_of = t[23] ? 24'(-t) : 24'(t);
  endfunction : mag_of

  function automatic cms_pkg::cms_seg_type rd_seg(input logic [3:0] i);
    rd_seg = q.fl_use ? flash[i] : ram[i];
  endfunction : rd_seg

  // ==========================================================
  // Next state
  always_comb
  begin
    d        = q;
    d.es_s   = {q.es_s[0], estop_pin};
    d.lw_s   = {q.lw_s[0], lim_cw_pin};
    d.lc_s   = {q.lc_s[0], lim_ccw_pin};
    d.p_es   = q.es_s[1];
    d.p_ld   = link.load_req;
    d.p_sv   = link.seg_valid;
    d.p_st   = link.start;
    d.p_hd   = link.hold;
    d.p_hn   = link.halt_now;
    d.step   = 1'b0;
    es_rise  = q.es_s[1] & ~q.p_es;
    hn_rise  = link.halt_now & ~q.p_hn;
    ld_rise  = link.load_req & ~q.p_ld;
    sv_rise  = link.seg_valid & ~q.p_sv;
    st_rise  = link.start & ~q.p_st;
    hd_rise  = link.hold & ~q.p_hd;
    go       = 1'b0;
    gi       = 4'h0;
    wr_seg   = 1'b0;
    ld_exit  = 1'b0;
    s        = rd_seg(q.idx);
    bad      = (q.cnt == SEG_MAX_W) || (mag_of(link.seg.target) == 24'h00_0000) ||
               (link.seg.period < cms_pkg::PERIOD_MIN);
    lim_dir  = q.dir ? q.lw_s[1] : q.lc_s[1];
    if (link.clear_faults)
    begin
      d.flt     = 1'b0;
      d.blk_cw  = 1'b0;
      d.blk_ccw = 1'b0;
    end
    if (config_load)
    begin
      d.valid  = 1'b0;
      d.fl_use = 1'b0;
    end
    if (!q.rest_done && configured && cmd_mode)
    begin
      d.rest_done = 1'b1;
      if (flash_sig == cms_pkg::FLASH_MAGIC && !q.valid && !config_load)
      begin
        d.valid  = 1'b1;
        d.fl_use = 1'b1;
        d.cnt    = flash_cnt;
      end
    end
    case (q.st)
      S_IDLE:
      begin
        if (q.lock)
        begin
          d.busy = 1'b0;
        end
        else if (ld_rise)
        begin
          d.st     = S_LREQ;
          d.ld     = 1'b1;
          d.sreq   = 1'b1;
          d.cnt    = 5'h00;
          d.valid  = 1'b0;
          d.fl_use = 1'b0;
          d.sv     = link.save_nv;
        end
        else if (st_rise)
        begin
          if (!q.valid)
          begin
            d.flt = 1'b1;
          end
          else if (!link.start_pausing && (link.dir_cw_req == link.dir_ccw_req))
          begin
            d.flt = 1'b1;
          end
          else
          begin
            d.cont = ~link.start_pausing;
            d.rdir = link.dir_cw_req;
            d.hold = 1'b0;
            go     = 1'b1;
          end
        end
      end
      S_LREQ:
      begin
        if (!link.load_req)
        begin
          ld_exit = 1'b1;
        end
        else if (sv_rise)
        begin
          d.st = S_LCHK;
        end
      end
      S_LCHK:
      begin
        d.sreq = 1'b0;
        d.st   = S_LWAIT;
        if (bad)
        begin
          d.flt = 1'b1;
        end
        else
        begin
          wr_seg = 1'b1;
          d.cnt  = q.cnt + 5'h01;
        end
      end
      S_LWAIT:
      begin
        if (!link.load_req)
        begin
          ld_exit = 1'b1;
        end
        else if (!link.seg_valid)
        begin
          d.sreq = 1'b1;
          d.st   = S_LREQ;
        end
      end
      S_RUN:
      begin
        if (hn_rise || es_rise)
        begin
          d.st   = S_IDLE;
          d.busy = 1'b0;
        end
        else if (lim_dir)
        begin
          d.st      = S_IDLE;
          d.busy    = 1'b0;
          d.blk_cw  = q.blk_cw | q.dir;
          d.blk_ccw = q.blk_ccw | ~q.dir;
        end
        else if (hd_rise && !q.hold)
        begin
          d.hold = 1'b1;
          d.left = (q.left < 24'(s.decel)) ? q.left : 24'(s.decel);
          if (s.decel == 16'h0000)
          begin
            d.st   = S_IDLE;
            d.busy = 1'b0;
          end
        end
        else if (q.tick <= 16'h0001)
        begin
          d.step = 1'b1;
          d.tick = s.period;
          d.left = q.left - 24'h00_0001;
          if (q.left == 24'h00_0001)
          begin
            if (q.hold || (5'(q.idx) + 5'h01 == q.cnt))
            begin
              d.st   = S_IDLE;
              d.busy = 1'b0;
            end
            else if (q.cont)
            begin
              go = 1'b1;
              gi = q.idx + 4'h1;
            end
            else
            begin
              // A zero pause still costs one idle cycle, so the direction
              // never changes under the last step of a segment.
              d.st   = S_PAUSE;
              d.pcnt = link.pause_time;
              d.pre  = (link.pause_time == 16'h0000) ? 8'h00 : PRE_RELOAD;
            end
          end
        end
        else
        begin
          d.tick = q.tick - 16'h0001;
        end
      end
      S_PAUSE:
      begin
        if (hn_rise || es_rise || hd_rise)
        begin
          d.st   = S_IDLE;
          d.busy = 1'b0;
        end
        else if (q.pre != 8'h00)
        begin
          d.pre = q.pre - 8'h01;
        end
        else if (q.pcnt <= 16'h0001)
        begin
          go = 1'b1;
          gi = q.idx + 4'h1;
        end
        else
        begin
          d.pcnt = q.pcnt - 16'h0001;
          d.pre  = PRE_RELOAD;
        end
      end
      default:
      begin
        d.st = S_IDLE;
      end
    endcase
    if (ld_exit)
    begin
      d.st    = S_IDLE;
      d.ld    = 1'b0;
      d.sreq  = 1'b0;
      d.valid = (q.cnt >= SEG_MIN_W);
      d.lock  = q.sv;
    end
    // Each segment is relative, so the start needs no preset or homing.
    if (go)
    begin
      s      = rd_seg(gi);
      d.idx  = gi;
      d.left = mag_of(s.target);
      d.tick = s.period;
      d.dir  = d.cont ? d.rdir : ~s.target[23];
      if ((d.dir && (q.blk_cw || q.lw_s[1])) || (!d.dir && (q.blk_ccw || q.lc_s[1])))
      begin
        d.st   = S_IDLE;
        d.busy = 1'b0;
        d.flt  = 1'b1;
      end
      else
      begin
        d.st   = S_RUN;
        d.busy = 1'b1;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Profile storage
  // The flash image is not reset on purpose: reset stands for a power
  // cycle, and the saved profile must outlive it.
  always_ff @(posedge core_clk)
  begin
    if (wr_seg)
    begin
      ram[q.cnt[3:0]] <= link.seg;
      if (q.sv)
      begin
        flash[q.cnt[3:0]] <= link.seg;
      end
    end
    if (ld_exit && q.sv && q.cnt >= SEG_MIN_W)
    begin
      flash_cnt <= q.cnt;
      flash_sig <= cms_pkg::FLASH_MAGIC;
    end
  end

  assign link.load_active   = q.ld;
  assign link.seg_request   = q.sreq;
  assign link.cmd_fault     = q.flt;
  assign link.busy          = q.busy;
  assign link.profile_valid = q.valid;
  assign step               = q.step;
  assign dir_cw             = q.dir;
  assign nv_locked          = q.lock;
endmodule : cms_device

// file: cms_host.sv
`timescale 1ns/100ps
module cms_host (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  cms_link_if.host         link,
  input  wire logic [4:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);
  typedef enum logic [1:0] {H_IDLE, H_WREQ, H_VALID} cms_host_state_type;

  typedef struct packed {
    cms_host_state_type   st;
    logic                 load_req;
    logic                 seg_valid;
    cms_pkg::cms_seg_type seg;
    logic                 start;
    logic                 pausing;
    logic                 cw;
    logic                 ccw;
    logic [15:0]          pause;
    logic                 hold;
    logic                 halt;
    logic                 clr;
    logic                 save;
    logic [4:0]           pushes;
    logic                 err;
    logic [31:0]          rdata;
  } cms_host_reg_type;

  localparam logic [4:0] SEG_MAX_W = 5'(cms_pkg::SEG_MAX);

  cms_host_reg_type q;
  cms_host_reg_type d;
  logic             cw_go;
  logic [31:0]      stat;

  // ==========================================================
  // Next state
  always_comb
  begin
    d       = q;
    d.start = 1'b0;
    d.hold  = 1'b0;
    d.halt  = 1'b0;
    d.clr   = 1'b0;
    cw_go   = wr && (addr == cms_pkg::ADR_CTRL);
    stat    = 32'h0000_0000;
    stat[cms_pkg::SB_LOAD_ACT] = link.load_active;
    stat[cms_pkg::SB_SEG_REQ]  = link.seg_request;
    stat[cms_pkg::SB_FAULT]    = link.cmd_fault;
    stat[cms_pkg::SB_BUSY]     = link.busy;
    stat[cms_pkg::SB_VALID]    = link.profile_valid;
    stat[cms_pkg::SB_HOST_ERR] = q.err;
    stat[cms_pkg::SB_PUSHING]  = (q.st != H_IDLE);
    stat[cms_pkg::SB_CNT_LSB +: 5] = q.pushes;
    if (wr && addr == cms_pkg::ADR_TGT)
    begin
      d.seg.target = wdata[23:0];
    end
    if (wr && addr == cms_pkg::ADR_PAR)
    begin
      d.seg.period = wdata[15:0];
      d.seg.decel  = wdata[31:16];
    end
    if (wr && addr == cms_pkg::ADR_RUN)
    begin
      d.pause   = wdata[15:0];
      d.pausing = wdata[cms_pkg::RB_PAUSING];
      d.cw      = wdata[cms_pkg::RB_CW];
      d.ccw     = wdata[cms_pkg::RB_CCW];
    end
    if (cw_go)
    begin
      d.hold = wdata[cms_pkg::CB_HOLD];
      d.halt = wdata[cms_pkg::CB_HALT];
      d.clr  = wdata[cms_pkg::CB_CLEAR];
      if (wdata[cms_pkg::CB_CLEAR])
      begin
        d.err = 1'b0;
      end
      if (wdata[cms_pkg::CB_LOAD_BEGIN] && !q.load_req)
      begin
        d.load_req = 1'b1;
        d.pushes   = 5'h00;
        d.save     = wdata[cms_pkg::CB_SAVE];
      end
      if (wdata[cms_pkg::CB_LOAD_END])
      begin
        d.load_req = 1'b0;
      end
      if (wdata[cms_pkg::CB_START])
      begin
        if (q.load_req || q.st != H_IDLE)
        begin
          d.err = 1'b1;
        end
        else
        begin
          d.start = 1'b1;
        end
      end
    end
    case (q.st)
      H_IDLE:
      begin
        if (cw_go && wdata[cms_pkg::CB_PUSH])
        begin
          if (!q.load_req || q.pushes == SEG_MAX_W)
          begin
            d.err = 1'b1;
          end
          else
          begin
            d.st = H_WREQ;
          end
        end
      end
      H_WREQ:
      begin
        if (link.seg_request)
        begin
          d.seg_valid = 1'b1;
          d.st        = H_VALID;
        end
      end
      H_VALID:
      begin
        if (!link.seg_request)
        begin
          d.seg_valid = 1'b0;
          d.pushes    = q.pushes + 5'h01;
          d.st        = H_IDLE;
        end
      end
      default:
      begin
        d.st = H_IDLE;
      end
    endcase
    // Reads answer one cycle later; unmapped addresses read as zero.
    d.rdata = 32'h0000_0000;
    if (rd)
    begin
      case (addr)
        cms_pkg::ADR_CTRL: d.rdata = stat;
        cms_pkg::ADR_STAT: d.rdata = stat;
        cms_pkg::ADR_TGT:  d.rdata = {{8{q.seg.target[23]}}, q.seg.target};
        cms_pkg::ADR_PAR:  d.rdata = {q.seg.decel, q.seg.period};
        cms_pkg::ADR_RUN:  d.rdata = {13'h0000, q.ccw, q.cw, q.pausing, q.pause};
        default:           d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.load_req      = q.load_req;
  assign link.seg_valid     = q.seg_valid;
  assign link.seg           = q.seg;
  assign link.start         = q.start;
  assign link.start_pausing = q.pausing;
  assign link.dir_cw_req    = q.cw;
  assign link.dir_ccw_req   = q.ccw;
  assign link.pause_time    = q.pause;
  assign link.hold          = q.hold;
  assign link.halt_now      = q.halt;
  assign link.clear_faults  = q.clr;
  assign link.save_nv       = q.save;
  assign rdata              = q.rdata;
endmodule : cms_host

// file: cms_link_if.sv
`timescale 1ns/100ps
interface cms_link_if;
  logic                load_req;
  logic                seg_valid;
  cms_pkg::cms_seg_type seg;
  logic                start;
  logic                start_pausing;
  logic                dir_cw_req;
  logic                dir_ccw_req;
  logic [15:0]         pause_time;
  logic                hold;
  logic                halt_now;
  logic                clear_faults;
  logic                save_nv;
  logic                load_active;
  logic                seg_request;
  logic                cmd_fault;
  logic                busy;
  logic                profile_valid;

  modport dev (input load_req, seg_valid, seg, start, start_pausing, dir_cw_req, dir_ccw_req,
               pause_time, hold, halt_now, clear_faults, save_nv,
               output load_active, seg_request, cmd_fault, busy, profile_valid);
  modport host (output load_req, seg_valid, seg, start, start_pausing, dir_cw_req, dir_ccw_req,
                pause_time, hold, halt_now, clear_faults, save_nv,
                input load_active, seg_request, cmd_fault, busy, profile_valid);
endinterface : cms_link_if

// file: cms_link_monitor.sv
`timescale 1ns/100ps
module cms_link_monitor (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic load_req,
  input wire logic seg_valid,
  input wire logic start,
  input wire logic hold,
  input wire logic halt_now,
  input wire logic clear_faults,
  input wire logic load_active,
  input wire logic seg_request,
  input wire logic cmd_fault,
  input wire logic busy,
  input wire logic profile_valid
);
  // ==========================================================
  // Link checks.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence load_opened;
    ##1 (load_active && seg_request);
  endsequence
  sequence seg_taken;
    ##[1:3] !seg_request;
  endsequence
  sequence seg_asked;
    ##[1:3] (seg_request || !load_req);
  endsequence

  load_start_a : assert property ($rose(load_req) |-> load_opened) else $error("load start");
  load_hold_a : assert property (load_active && load_req |=> load_active) else $error("load hold");
  req_in_load_a : assert property (seg_request |-> load_active) else $error("request outside load");
  seg_drop_a : assert property ($rose(seg_valid) && load_active |-> seg_taken) else $error("segment drop");
  re_request_a : assert property ($fell(seg_valid) && load_req |-> seg_asked) else $error("re request");
  load_end_a : assert property (!load_req |=> !load_active && !seg_request) else $error("load end");
  halt_stop_a : assert property ($rose(halt_now) && busy |-> ##[1:2] !busy) else $error("halt stop");
  hold_end_a : assert property ($rose(hold) && busy |-> ##[1:200] !busy) else $error("hold end");
  no_profile_a : assert property ($rose(start) && !profile_valid && !busy |-> ##[1:3] cmd_fault)
    else $error("start without profile");
  // The fault must survive until a clear; the device clears on the clear_faults level, so the second cycle of quiet is only margin.
  fault_sticky_a : assert property (cmd_fault && !clear_faults && !$past(clear_faults) |=> cmd_fault)
    else $error("fault sticky");
endmodule : cms_link_monitor

// file: cms_pkg.sv
// ==========================================================
// Notes on behaviour
// - Relative segments run from any position.
// - Profile kept until power, config, reload.
// - Saved profile restored once configured, commanding.
// - Continuous move runs in host-chosen direction.
// - Hold in continuous move decelerates, ends, final.
// - Hold in pausing move decelerates, ends, final.
// - Halt-now rising edge stops immediately.
// - Emergency-stop input rising edge stops immediately.
// - Travel-side limit stops, blocks until clear.
// - Pausing move waits one pause between segments.
// - Pausing segment sign selects shaft direction.
// - Continuous move uses magnitude, one direction.
// - Host loads all segments before starting.
// - Same load path; start bit picks type.
// - Load request edge raises active and request; the code takes it only when idle and not nv_locked after a save.
// - Host data-valid edge marks segment present.
// - Load-active stays set while accepting segments.
// - Segment-request rising edge asks next segment.
// - Validate segment, drop request, fault if bad.
// - Valid low after request drop re-requests.
// - At most sixteen segments per profile.
// - Load request low clears active and request.
// ==========================================================
package cms_pkg;
  localparam int          SEG_MAX        = 16;
  localparam int          SEG_MIN        = 2;
  localparam int          CLK_NS         = 4;
  localparam int          PAUSE_UNIT_NS  = 1000;
  localparam int          PAUSE_UNIT_CYC = PAUSE_UNIT_NS / CLK_NS;
  localparam logic [15:0] PERIOD_MIN     = 16'h0004;
  localparam logic [31:0] FLASH_MAGIC    = 32'h5a5a_c3c3;
  localparam logic [4:0]  ADR_CTRL       = 5'h00;
  localparam logic [4:0]  ADR_TGT        = 5'h04;
  localparam logic [4:0]  ADR_PAR        = 5'h08;
  localparam logic [4:0]  ADR_RUN        = 5'h0c;
  localparam logic [4:0]  ADR_STAT       = 5'h10;
  localparam int          CB_LOAD_BEGIN  = 0;
  localparam int          CB_LOAD_END    = 1;
  localparam int          CB_PUSH        = 2;
  localparam int          CB_START       = 3;
  localparam int          CB_HOLD        = 4;
  localparam int          CB_HALT        = 5;
  localparam int          CB_CLEAR       = 6;
  localparam int          CB_SAVE        = 7;
  localparam int          RB_PAUSING     = 16;
  localparam int          RB_CW          = 17;
  localparam int          RB_CCW         = 18;
  localparam int          SB_LOAD_ACT    = 0;
  localparam int          SB_SEG_REQ     = 1;
  localparam int          SB_FAULT       = 2;
  localparam int          SB_BUSY        = 3;
  localparam int          SB_VALID       = 4;
  localparam int          SB_HOST_ERR    = 5;
  localparam int          SB_PUSHING     = 6;
  localparam int          SB_CNT_LSB     = 8;

  typedef struct packed {
    logic signed [23:0] target;
    logic [15:0]        period;
    logic [15:0]        decel;
  } cms_seg_type;
endpackage : cms_pkg
